// ==== port_ctrl_regs.vh ====
`ifndef PORT_CTRL_REGS_VH
`define PORT_CTRL_REGS_VH
`define MODE_QUASI 2'h0
`define MODE_PUSH_PULL 2'h1
`define MODE_INPUT_ONLY 2'h2
`define MODE_OPEN_DRAIN 2'h3
`define LATCH_RESET 8'hFF
`define P3_LATCH_RESET 8'h03
`define MODE_RESET 8'h00
`define SCHMITT_RESET 4'h0
`define I2C_CLK_BIT 3'h2
`define I2C_DAT_BIT 3'h3
`define XTAL_OUT_BIT 3'h0
`define XTAL_IN_BIT 3'h1
`define STRONG_CYCLES 2'h2
`define CLKOUT_HALF 2'h1
`define OP_WRITE 3'h0
`define OP_AND 3'h1
`define OP_OR 3'h2
`define OP_XOR 3'h3
`define OP_INC 3'h4
`define OP_DEC 3'h5
`define OP_BIT 3'h6
`define OP_NONE 3'h7
`define PORT_BITS 8
`define PORT1_BASE 8
`define PORT3_BASE 24
`define CLKOUT_LAST 2'h3
`endif

// ==== pin_cell.v ====
`timescale 1ns/10ps
`include "port_ctrl_regs.vh"
module pin_cell
(
  input wire ref_clk,
  input wire srst,
  input wire periph_en,
  input wire [1:0] mode,
  input wire latch,
  input wire pin_sync,
  input wire disable_pin,
  output reg strong_up,
  output reg weak_up,
  output reg very_weak_up,
  output reg pull_down
);
  reg latch_prev_q;
  reg [1:0] strong_cnt_q;
  // =============================================
  // Strong pull-up timer
  always @(posedge ref_clk)
  begin
    if (srst)
    begin
      latch_prev_q <= 1'b1;
      strong_cnt_q <= 2'h0;
    end
    else
    begin
      latch_prev_q <= latch;
      if (mode == `MODE_QUASI && latch && !latch_prev_q)
        strong_cnt_q <= `STRONG_CYCLES;
      else if (!latch || mode != `MODE_QUASI)
        strong_cnt_q <= 2'h0;
      else if (periph_en && strong_cnt_q != 2'h0)
        strong_cnt_q <= strong_cnt_q - 2'h1;
    end
  end
  // =============================================
  // Driver selection
  always @(posedge ref_clk)
  begin
    if (srst)
    begin
      strong_up <= 1'b0;
      weak_up <= 1'b0;
      very_weak_up <= 1'b0;
      pull_down <= 1'b0;
    end
    else if (disable_pin)
    begin
      strong_up <= 1'b0;
      weak_up <= 1'b0;
      very_weak_up <= 1'b0;
      pull_down <= 1'b0;
    end
    else
    begin
      // Pull-down shared by quasi, push-pull and open drain
      pull_down <= !latch && mode != `MODE_INPUT_ONLY;
      case (mode)
        `MODE_QUASI:
        begin
          strong_up <= latch && (strong_cnt_q != 2'h0 || (!latch_prev_q));
          weak_up <= latch && pin_sync;
          very_weak_up <= latch;
        end
        `MODE_PUSH_PULL:
        begin
          strong_up <= latch;
          weak_up <= 1'b0;
          very_weak_up <= 1'b0;
        end
        default:
        begin
          strong_up <= 1'b0;
          weak_up <= 1'b0;
          very_weak_up <= 1'b0;
        end
      endcase
    end
  end
endmodule

// ==== port_pin_mode_control.v ====
`timescale 1ns/10ps
`include "port_ctrl_regs.vh"
module port_pin_mode_control
(
  input wire ref_clk,
  input wire srst,
  input wire periph_en,
  input wire [1:0] port_sel,
  input wire [2:0] port_op,
  input wire [7:0] op_data,
  input wire [2:0] op_bit,
  input wire op_bit_val,
  input wire mode_we,
  input wire [7:0] mode_cfg_bit_low,
  input wire [7:0] mode_cfg_bit_high,
  input wire [3:0] schmitt_sel_in,
  input wire schmitt_we,
  input wire clk_out_en,
  input wire clk_src_rc_or_xtal,
  input wire xtal_option,
  input wire [31:0] pin_in,
  output reg [7:0] latch_rd_data,
  output reg [7:0] pin_rd_data,
  output reg [3:0] schmitt_sel,
  output reg [31:0] strong_up,
  output reg [31:0] weak_up,
  output reg [31:0] very_weak_up,
  output reg [31:0] pull_down,
  output reg clk_out
);
  reg [31:0] port_output_latch_q;
  reg [31:0] mode_low_q;
  reg [31:0] mode_high_q;
  reg [31:0] sync1_q;
  reg [31:0] sync2_q;
  reg [1:0] div_q;
  reg [7:0] cur_latch;
  reg [7:0] new_latch;
  reg [31:0] xtal_mask;
  wire [31:0] cell_su;
  wire [31:0] cell_wu;
  wire [31:0] cell_vw;
  wire [31:0] cell_pd;

  function [7:0] sel_byte;
    input [31:0] v;
    input [1:0] idx;
    begin
      sel_byte = v[idx*`PORT_BITS +: `PORT_BITS];
    end
  endfunction

  function [1:0] pin_mode;
    input [31:0] lo;
    input [31:0] hi;
    input integer n;
    begin
      // I2C pins fixed open drain
      if (n == `PORT1_BASE + `I2C_CLK_BIT || n == `PORT1_BASE + `I2C_DAT_BIT)
        pin_mode = `MODE_OPEN_DRAIN;
      else
        pin_mode = {lo[n], hi[n]};
    end
  endfunction

  // =============================================
  // Read-modify-write on the latch
  always @*
  begin
    cur_latch = sel_byte(port_output_latch_q, port_sel);
    new_latch = cur_latch;
    case (port_op)
      `OP_WRITE: new_latch = op_data;
      `OP_AND: new_latch = cur_latch & op_data;
      `OP_OR: new_latch = cur_latch | op_data;
      `OP_XOR: new_latch = cur_latch ^ op_data;
      `OP_INC: new_latch = cur_latch + 8'h01;
      `OP_DEC: new_latch = cur_latch - 8'h01;
      `OP_BIT: new_latch[op_bit] = op_bit_val;
      default: new_latch = cur_latch;
    endcase
  end

  always @(posedge ref_clk)
  begin
    if (srst)
    begin
      port_output_latch_q <= {`P3_LATCH_RESET, `LATCH_RESET, `LATCH_RESET, `LATCH_RESET};
      mode_low_q <= {4{`MODE_RESET}};
      mode_high_q <= {4{`MODE_RESET}};
      schmitt_sel <= `SCHMITT_RESET;
      latch_rd_data <= 8'h00;
      pin_rd_data <= 8'h00;
    end
    else
    begin
      if (port_op != `OP_NONE)
        port_output_latch_q[port_sel*`PORT_BITS +: `PORT_BITS] <= new_latch;
      if (mode_we)
      begin
        mode_low_q[port_sel*`PORT_BITS +: `PORT_BITS] <= mode_cfg_bit_low;
        mode_high_q[port_sel*`PORT_BITS +: `PORT_BITS] <= mode_cfg_bit_high;
      end
      if (schmitt_we)
        schmitt_sel <= schmitt_sel_in;
      latch_rd_data <= cur_latch;
      pin_rd_data <= sel_byte(sync2_q & ~xtal_mask, port_sel);
    end
  end

  // =============================================
  // Pin synchronizer
  always @(posedge ref_clk)
  begin
    if (srst)
    begin
      sync1_q <= 32'h0;
      sync2_q <= 32'h0;
    end
    else
    begin
      sync1_q <= pin_in;
      sync2_q <= sync1_q;
    end
  end

  // =============================================
  // Clock output divided by four
  always @(posedge ref_clk)
  begin
    if (srst)
    begin
      div_q <= 2'h0;
      clk_out <= 1'b0;
    end
    else if (clk_out_en && clk_src_rc_or_xtal)
    begin
      div_q <= div_q + 2'h1;
      if (div_q == `CLKOUT_HALF)
        clk_out <= !clk_out;
      else if (div_q == `CLKOUT_LAST)
        clk_out <= !clk_out;
    end
    else
    begin
      div_q <= 2'h0;
      clk_out <= 1'b0;
    end
  end

  // =============================================
  // Crystal pin masks
  // Crystal pins lose both directions; reads see 0 so a swinging oscillator never leaks in
  always @*
  begin
    xtal_mask = 32'h0;
    xtal_mask[`PORT3_BASE + `XTAL_OUT_BIT] = xtal_option;
    xtal_mask[`PORT3_BASE + `XTAL_IN_BIT] = xtal_option;
  end

  // =============================================
  // Per-pin drivers
  genvar g;
  generate
    for (g = 0; g < 32; g = g + 1)
    begin : pin_gen
      pin_cell u_cell
      (
        .ref_clk(ref_clk),
        .srst(srst),
        .periph_en(periph_en),
        .mode(pin_mode(mode_low_q, mode_high_q, g)),
        .latch(port_output_latch_q[g]),
        .pin_sync(sync2_q[g]),
        .disable_pin(xtal_mask[g]),
        .strong_up(cell_su[g]),
        .weak_up(cell_wu[g]),
        .very_weak_up(cell_vw[g]),
        .pull_down(cell_pd[g])
      );
    end
  endgenerate

  always @*
  begin
    strong_up = cell_su;
    weak_up = cell_wu;
    very_weak_up = cell_vw;
    pull_down = cell_pd;
  end
endmodule

// ==== port_mon_monitor.sv ====
`timescale 1ns/10ps
`include "port_ctrl_regs.vh"
module port_mon
(
  input wire ref_clk,
  input wire srst,
  input wire schmitt_we,
  input wire clk_out_en,
  input wire clk_src_rc_or_xtal,
  input wire clk_out,
  input wire [1:0] port_sel,
  input wire [2:0] port_op,
  input wire [7:0] op_data,
  input wire [7:0] latch_rd_data,
  input wire [3:0] schmitt_sel_in,
  input wire [3:0] schmitt_sel,
  input wire [31:0] strong_up,
  input wire [31:0] weak_up,
  input wire [31:0] very_weak_up,
  input wire [31:0] pull_down
);
  // ====================
  // Checks
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  wire [31:0] ups = strong_up | weak_up | very_weak_up;
  wire run = clk_out_en & clk_src_rc_or_xtal;
  sequence s_wr;
    port_op == `OP_WRITE ##1 port_op == `OP_NONE && $stable(port_sel);
  endsequence
  sequence s_or;
    port_op == `OP_NONE ##1 port_op == `OP_OR && $stable(port_sel)
    ##1 port_op == `OP_NONE && $stable(port_sel);
  endsequence
  chk_scl_open_drain: assert property (!ups[10])
    else $error("pull-up on clock pin");
  chk_sda_open_drain: assert property (!ups[11])
    else $error("pull-up on data pin");
  chk_no_fight: assert property ((pull_down & strong_up) == 32'h0)
    else $error("pull-down and strong pull-up together");
  chk_schmitt_load: assert property (schmitt_we |=> schmitt_sel == $past(schmitt_sel_in))
    else $error("schmitt select not loaded");
  chk_clkout_div: assert property (run [*6] |-> clk_out != $past(clk_out, 2))
    else $error("clock out not divided by four");
  chk_write_pass: assert property (s_wr |=> latch_rd_data == $past(op_data, 2))
    else $error("written latch value lost");
  // Previous read-back stands in for the latch: pin level must not leak in
  chk_or_latch: assert property (s_or |=>
    latch_rd_data == ($past(latch_rd_data, 2) | $past(op_data, 2)))
    else $error("or did not use the latch");
  chk_reset_quiet: assert property (disable iff (1'h0) srst |=>
    (ups | pull_down) == 32'h0 && schmitt_sel == 4'h0)
    else $error("outputs active in reset");
endmodule
bind port_pin_mode_control port_mon u_mon (.*);

// ==== pin_world.sv ====
`timescale 1ns/10ps
module pin_world
(
  input wire ref_clk,
  input wire [31:0] strong_up,
  input wire [31:0] weak_up,
  input wire [31:0] very_weak_up,
  input wire [31:0] pull_down,
  input wire [31:0] ext_low,
  output wire [31:0] pin_in
);
  // ====================
  // Board
  localparam [31:0] BOARD_PU = 32'h00000C00;
  // Undriven pins wander so a stale level cannot pass
  reg flt = 1'h0;
  always @(posedge ref_clk) flt <= ~flt;
  assign pin_in = ~(pull_down | ext_low) &
    (strong_up | weak_up | very_weak_up | BOARD_PU | {32{flt}});
endmodule

// ==== port_pin_mode_control_tb.sv ====
`timescale 1ns/10ps
`include "port_ctrl_regs.vh"
module port_pin_mode_control_tb;
  reg ref_clk = 1'h0, srst = 1'h1, periph_en = 1'h0, mode_we = 1'h0, op_bit_val = 1'h0;
  reg schmitt_we = 1'h0, clk_out_en = 1'h0, clk_src_rc_or_xtal = 1'h0, xtal_option = 1'h0, v;
  reg [1:0] port_sel = 2'h0;
  reg [2:0] port_op = 3'h7, op_bit = 3'h0;
  reg [7:0] op_data = 8'h00, mode_cfg_bit_low = 8'h00, mode_cfg_bit_high = 8'h00;
  reg [3:0] schmitt_sel_in = 4'h0;
  reg [31:0] ext_low = 32'h0;
  wire [31:0] pin_in, strong_up, weak_up, very_weak_up, pull_down;
  wire [7:0] latch_rd_data, pin_rd_data;
  wire [3:0] schmitt_sel;
  wire clk_out;
  integer errors = 0, cmp_count = 0, i, n;
  // Drive nibbles {strong, weak, very weak, down} per mode and latch value
  localparam [31:0] MX = 32'h010081A1;
  port_pin_mode_control uut (.*);
  pin_world partner (.*);
  initial
  begin
    forever #5 ref_clk = ~ref_clk;
  end
  // ====================
  // Helpers
  task cy(input integer k);
    repeat (k) @(negedge ref_clk);
  endtask
  task chk(input string nm, input [31:0] got, input [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch %0s exp %h got %h", nm, exp, got);
    end
  endtask
  task op(input [1:0] p, input [2:0] o, input [7:0] d);
    port_sel = p;
    port_op = o;
    op_data = d;
    cy(1);
    port_op = `OP_NONE;
    cy(2);
  endtask
  task md(input [1:0] p, input [7:0] lo, input [7:0] hi);
    port_sel = p;
    mode_cfg_bit_low = lo;
    mode_cfg_bit_high = hi;
    mode_we = 1'h1;
    cy(1);
    mode_we = 1'h0;
  endtask
  task pulse;
    periph_en = 1'h1;
    cy(1);
    periph_en = 1'h0;
    cy(1);
  endtask
  // ====================
  // Scenarios
  task t_reset;
    port_sel = 2'h3;
    cy(2);
    chk("p3 latch", latch_rd_data, 8'h03);
    chk("p3 vweak", very_weak_up[25:24], 2'h3);
    xtal_option = 1'h1;
    cy(3);
    chk("xtal", {strong_up[25:24], weak_up[25:24], very_weak_up[25:24], pull_down[25:24]}, 8'h0);
    chk("xtal in", pin_rd_data[1:0], 2'h0);
    xtal_option = 1'h0;
    $display("end reset");
  endtask
  task t_quasi;
    op(2'h0, `OP_WRITE, 8'h00);
    chk("low", pull_down[7:0], 8'hFF);
    op(2'h0, `OP_WRITE, 8'hFF);
    chk("strong", strong_up[7:0], 8'hFF);
    pulse;
    chk("strong 1", strong_up[0], 1'h1);
    pulse;
    cy(1);
    chk("strong 2", {strong_up[0], weak_up[0]}, 2'h1);
    ext_low[0] = 1'h1;
    cy(5);
    chk("weak off", {weak_up[0], very_weak_up[0]}, 2'h1);
    chk("pin read", pin_rd_data[0], 1'h0);
    op(2'h0, `OP_INC, 8'h00);
    chk("inc", latch_rd_data, 8'h00);
    op(2'h0, `OP_DEC, 8'h00);
    chk("dec", latch_rd_data, 8'hFF);
    op_bit = 3'h3;
    op(2'h0, `OP_BIT, 8'h00);
    chk("bit", latch_rd_data, 8'hF7);
    op(2'h0, `OP_AND, 8'h0F);
    chk("and", latch_rd_data, 8'h07);
    op(2'h0, `OP_OR, 8'h30);
    chk("or", latch_rd_data, 8'h37);
    op(2'h0, `OP_XOR, 8'h0F);
    chk("xor", latch_rd_data, 8'h38);
    op_bit = 3'h0;
    op_bit_val = 1'h1;
    op(2'h0, `OP_BIT, 8'h00);
    chk("set bit", latch_rd_data, 8'h39);
    ext_low[0] = 1'h0;
    $display("end quasi");
  endtask
  task t_modes;
    for (i = 0; i < 8; i++)
    begin
      md(2'h2, {7'h0, i[2]}, {7'h0, i[1]});
      op(2'h2, `OP_WRITE, {7'h0, i[0]});
      chk("mode", {strong_up[16], weak_up[16], very_weak_up[16], pull_down[16]}, MX[4*i +: 4]);
    end
    md(2'h2, 8'h00, 8'h00);
    $display("end modes");
  endtask
  task t_i2c;
    md(2'h1, 8'hFF, 8'h00);
    op(2'h1, `OP_WRITE, 8'hF3);
    chk("i2c low", pull_down[11:10], 2'h3);
    op(2'h1, `OP_WRITE, 8'hFF);
    chk("i2c rel", pull_down[11:10], 2'h0);
    md(2'h1, 8'h00, 8'h00);
    $display("end i2c");
  endtask
  task t_misc;
    schmitt_sel_in = 4'hA;
    schmitt_we = 1'h1;
    cy(1);
    schmitt_we = 1'h0;
    cy(1);
    chk("schmitt", schmitt_sel, 4'hA);
    clk_out_en = 1'h1;
    clk_src_rc_or_xtal = 1'h1;
    cy(4);
    n = 0;
    repeat (32)
    begin
      v = clk_out;
      cy(1);
      if (clk_out !== v)
        n++;
    end
    chk("clk out", n, 32'h10);
    $display("end misc");
  endtask
  task complete_run;
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    cy(2);
    srst = 1'h0;
    t_reset;
    t_quasi;
    t_modes;
    t_i2c;
    t_misc;
    complete_run;
  end
  initial
  begin
    #20000;
    errors++;
    complete_run;
  end
endmodule
